// *** verilog/boot_chip_select_router.sv ***
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Codes 0000-0111: cs0 NOR, cs1 emulator, spares NAND
// - Invert A23-A25 by code for virtual banks
// - Code 1000 swaps cs0/cs1, no inversion
// - Code 1001: NAND cs2, emulator cs1, NOR others
// - Chip select three reaches internal registers
// - Processor boots over chip select zero
// - Sixteen-bit bus, upper address word latched
// - Multiplex debug resets, add own system resets
// - Legacy hard request drives power-on reset
// - Legacy soft request drives hard reset line
// - Cold and warm resets assert power-on reset
// - Hard reset line: drive low or release
// - Processor GPIO selects both management muxes
// - First mux: RGMII, slot4, slot3, slot5
// - Drive USB identification pin for peripheral mode
// - Arbitrary clock marks speed code invalid
// - Software keeps clock MHz in auxiliary register
module boot_chip_select_router (
  // Clock and reset
  input  wire logic                                  REF_CLK,
  input  wire logic                                  ARST_N,
  // Local bus and debug requests
  lbus_if.dev                                        BUS,
  // Board straps and reset requests
  input  wire logic [3:0]                            BOOT_MAP,
  input  wire logic [boot_router_pkg::CLKSEL_W-1:0]  CLK_SPEED_SW,
  input  wire logic                                  COLD_RST_REQ,
  input  wire logic                                  WARM_RST_REQ,
  // Flash selects and address
  output logic                                       NOR_CS_N,
  output logic                                       EMU_CS_N,
  output logic      [boot_router_pkg::NAND_W-1:0]    NAND_CS_N,
  output logic      [boot_router_pkg::BANK_W-1:0]    FLASH_ADDR_HI,
  // Processor resets
  output logic                                       POWER_ON_RESET_IN_N,
  output logic                                       HARD_RESET_LINE_O,
  output logic                                       HARD_RESET_LINE_OE,
  // Board control
  output logic                                       USB_ID,
  output logic      [boot_router_pkg::MGMT1_W-1:0]   MGMT1_EN,
  output logic      [boot_router_pkg::MGMT2_W-1:0]   MGMT2_EN
);
  import boot_router_pkg::*;

  localparam int SYNC_W = 4 + CLKSEL_W + 2;

  typedef struct packed {
    logic                 locked;
    logic [1:0]           settle;
    logic [3:0]           boot_map;
    logic [BUS_W-1:0]     addr_latch;
    logic                 nor_cs_n;
    logic                 emu_cs_n;
    logic [NAND_W-1:0]    nand_cs_n;
    logic [BANK_W-1:0]    fa_hi;
    logic                 por_n;
    logic                 dbg_hard_reset_req_o;
    logic                 dbg_hard_reset_req_oe;
    logic                 usb_periph;
    logic                 dbg_src;
    logic                 arbitrary;
    logic [BUS_W-1:0]     aux;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [MGMT1_W-1:0]   mgmt1;
    logic [MGMT2_W-1:0]   mgmt2;
    logic                 ack;
    logic [BUS_W-1:0]     rdata;
  } dev_state_s;

  localparam dev_state_s DEV_RESET = '{
    nor_cs_n:  1'b1,
    emu_cs_n:  1'b1,
    nand_cs_n: 4'hF,
    por_n:     1'b0,
    default:   '0
  };

  dev_state_s          s;
  dev_state_s          next_s;
  logic [SYNC_W-1:0]   pins_sync;
  logic [3:0]          pin_map;
  logic [CLKSEL_W-1:0] pin_clk;
  logic                pin_cold;
  logic                pin_warm;

  // Board pins enter through two flip-flops
  pin_sync2 #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .d      ({BOOT_MAP, CLK_SPEED_SW, COLD_RST_REQ, WARM_RST_REQ}),
    .q      (pins_sync)
  );

  assign {pin_map, pin_clk, pin_cold, pin_warm} = pins_sync;

  // Next-state logic
  always_comb begin
    logic             reg_hit;
    logic [1:0]       idx;
    logic [BUS_W-1:0] rd_val;
    logic             hard_sel;
    logic             soft_sel;
    logic [1:0]       sel1;
    logic [1:0]       sel2;
    reg_hit  = 1'b0;
    idx      = 2'h0;
    rd_val   = '0;
    hard_sel = 1'b0;
    soft_sel = 1'b0;
    sel1     = 2'h0;
    sel2     = 2'h0;
    next_s   = s;

    if (!s.locked) begin
      if (s.settle == SETTLE_DONE) begin
        next_s.locked   = 1'b1;
        next_s.boot_map = pin_map;
      end else begin
        next_s.settle = s.settle + 2'h1;
      end
    end

    if (BUS.ale) begin
      next_s.addr_latch = BUS.ad;
    end

    // Chip select routing, all deselected before lock
    next_s.nor_cs_n  = 1'b1;
    next_s.emu_cs_n  = 1'b1;
    next_s.nand_cs_n = '1;
    next_s.fa_hi     = s.addr_latch[BANK_LSB +: BANK_W];
    if (s.locked) begin
      if (s.boot_map == MAP_EMU_BOOT) begin
        next_s.nor_cs_n  = BUS.cs_n[CS_EMU];
        next_s.emu_cs_n  = BUS.cs_n[CS_BOOT];
        next_s.nand_cs_n = {BUS.cs_n[CS_SPR_D], BUS.cs_n[CS_SPR_C], BUS.cs_n[CS_SPR_B], BUS.cs_n[CS_SPR_A]};
      end else if (s.boot_map == MAP_NAND_BOOT) begin
        next_s.nor_cs_n  = BUS.cs_n[CS_BOOT] & BUS.cs_n[CS_SPR_B] & BUS.cs_n[CS_SPR_C] & BUS.cs_n[CS_SPR_D];
        next_s.emu_cs_n  = BUS.cs_n[CS_EMU];
        next_s.nand_cs_n = {3'h7, BUS.cs_n[CS_SPR_A]};
      end else begin
        // normal NOR boot; invalid codes land here too
        next_s.nor_cs_n  = BUS.cs_n[CS_BOOT];
        next_s.emu_cs_n  = BUS.cs_n[CS_EMU];
        next_s.nand_cs_n = {BUS.cs_n[CS_SPR_D], BUS.cs_n[CS_SPR_C], BUS.cs_n[CS_SPR_B], BUS.cs_n[CS_SPR_A]};
        // bank inversion, skipped for invalid codes
        if (!s.boot_map[MAP_HI_BIT]) begin
          next_s.fa_hi = s.addr_latch[BANK_LSB +: BANK_W] ^ s.boot_map[BANK_W-1:0];
        end
      end
    end

    // Read value of the addressed register
    idx = s.addr_latch[REG_IDX_LSB +: REG_IDX_W];
    case (idx)
      REG_CTRL: begin
        rd_val[CTRL_USB_PERIPH] = s.usb_periph;
        rd_val[CTRL_SYS_RST]    = (s.rst_cnt != RST_CNT_ZERO);
        rd_val[CTRL_DBG_SRC]    = s.dbg_src;
      end
      REG_CLK: begin
        // speed code flagged invalid when arbitrary
        rd_val[CLK_CODE_LSB +: CLKSEL_W] = pin_clk;
        rd_val[CLK_ARB]                  = s.arbitrary;
        rd_val[CLK_VALID]                = !s.arbitrary;
      end
      REG_AUX: begin
        rd_val = s.aux;
      end
      default: begin
        rd_val[STAT_MAP_LSB +: 4] = s.boot_map;
        rd_val[STAT_LOCKED]       = s.locked;
      end
    endcase

    // Reset pulse counter runs down
    if (s.rst_cnt != RST_CNT_ZERO) begin
      next_s.rst_cnt = s.rst_cnt - 6'h01;
    end

    // register space on chip select three
    reg_hit    = !BUS.cs_n[CS_REGS] && (BUS.rd || BUS.wr);
    next_s.ack = reg_hit;
    if (reg_hit) begin
      next_s.rdata = rd_val;
    end
    if (reg_hit && BUS.wr) begin
      case (idx)
        REG_CTRL: begin
          next_s.usb_periph = BUS.wdata[CTRL_USB_PERIPH];
          next_s.dbg_src    = BUS.wdata[CTRL_DBG_SRC];
          if (BUS.wdata[CTRL_SYS_RST]) begin
            next_s.rst_cnt = RST_CNT_LOAD;
          end
        end
        REG_CLK: begin
          next_s.arbitrary = BUS.wdata[CLK_ARB];
        end
        REG_AUX: begin
          next_s.aux = BUS.wdata;
        end
        default: begin
          next_s.aux = s.aux;
        end
      endcase
    end

    hard_sel = s.dbg_src ? BUS.dbg2_hard_reset_req : BUS.dbg_hard_reset_req;
    soft_sel = s.dbg_src ? BUS.dbg2_soft_reset_req : BUS.dbg_soft_reset_req;

    next_s.por_n = !(hard_sel || pin_cold || pin_warm || (s.rst_cnt != RST_CNT_ZERO));

    next_s.dbg_hard_reset_req_o  = 1'b0;
    next_s.dbg_hard_reset_req_oe = soft_sel;

    sel1         = {BUS.gpio_sel[0], BUS.gpio_sel[1]};
    next_s.mgmt1 = '0;
    next_s.mgmt1[sel1] = 1'b1;

    // Second management mux, two populated slots
    sel2                      = {BUS.gpio_sel[2], BUS.gpio_sel[3]};
    next_s.mgmt2              = '0;
    next_s.mgmt2[MGMT2_SLOT4] = (sel2 == SEL2_SLOT4);
    next_s.mgmt2[MGMT2_SLOT5] = (sel2 == SEL2_SLOT5);
  end

  // State register
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= DEV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign NOR_CS_N            = s.nor_cs_n;
  assign EMU_CS_N            = s.emu_cs_n;
  assign NAND_CS_N           = s.nand_cs_n;
  assign FLASH_ADDR_HI       = s.fa_hi;
  assign POWER_ON_RESET_IN_N = s.por_n;
  assign HARD_RESET_LINE_O   = s.dbg_hard_reset_req_o;
  assign HARD_RESET_LINE_OE  = s.dbg_hard_reset_req_oe;
  assign USB_ID              = s.usb_periph;
  assign MGMT1_EN            = s.mgmt1;
  assign MGMT2_EN            = s.mgmt2;
  assign BUS.ack             = s.ack;
  assign BUS.rdata           = s.rdata;

endmodule

// *** verilog/boot_router_pkg.sv ***
package boot_router_pkg;

  // Clock rate and derived timing
  localparam int REF_CLK_MHZ       = 40;
  localparam int SYS_RST_PULSE_NS  = 1000;
  localparam int SYS_RST_PULSE_CYC = (SYS_RST_PULSE_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int RST_CNT_W         = 6;
  localparam logic [RST_CNT_W-1:0] RST_CNT_LOAD = RST_CNT_W'(SYS_RST_PULSE_CYC);
  localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 6'h00;

  // Local bus shape
  localparam int NUM_CS   = 7;
  localparam int BUS_W    = 16;
  localparam int NAND_W   = 4;
  localparam int BANK_W   = 3;
  localparam int GPIO_W   = 4;
  localparam int MGMT1_W  = 4;
  localparam int MGMT2_W  = 2;
  localparam int CLKSEL_W = 3;

  // Processor chip select numbers
  localparam int CS_BOOT  = 0;
  localparam int CS_EMU   = 1;
  localparam int CS_SPR_A = 2;
  localparam int CS_REGS  = 3;
  localparam int CS_SPR_B = 4;
  localparam int CS_SPR_C = 5;
  localparam int CS_SPR_D = 6;
  localparam logic [2:0] CS_REGS_NUM = 3'h3;
  localparam logic [2:0] CS_LAST_NUM = 3'h6;
  localparam logic [2:0] CS_BOOT_NUM = 3'h0;

  // Boot map codes
  localparam logic [3:0] MAP_DEFAULT   = 4'h0;
  localparam logic [3:0] MAP_EMU_BOOT  = 4'h8;
  localparam logic [3:0] MAP_NAND_BOOT = 4'h9;
  localparam int         MAP_HI_BIT    = 3;
  localparam logic [1:0] SETTLE_DONE   = 2'h3;

  // Latched address word holds A25..A10
  localparam int BANK_LSB    = 13;
  localparam int REG_IDX_LSB = 0;
  localparam int REG_IDX_W   = 2;

  // Router register indices
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_CLK    = 2'h1;
  localparam logic [1:0] REG_AUX    = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;

  // Router register fields
  localparam int CTRL_USB_PERIPH = 0;
  localparam int CTRL_SYS_RST    = 1;
  localparam int CTRL_DBG_SRC    = 2;
  localparam int CLK_CODE_LSB    = 0;
  localparam int CLK_ARB         = 3;
  localparam int CLK_VALID       = 4;
  localparam int STAT_MAP_LSB    = 0;
  localparam int STAT_LOCKED     = 4;

  // Management mux outputs
  localparam int         MGMT2_SLOT4 = 0;
  localparam int         MGMT2_SLOT5 = 1;
  localparam logic [1:0] SEL2_SLOT4  = 2'h1;
  localparam logic [1:0] SEL2_SLOT5  = 2'h3;

  // Controller APB map
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  localparam logic [APB_ADDR_W-1:0] APB_CTRL   = 12'h000;
  localparam logic [APB_ADDR_W-1:0] APB_CMD    = 12'h004;
  localparam logic [APB_ADDR_W-1:0] APB_WDATA  = 12'h008;
  localparam logic [APB_ADDR_W-1:0] APB_STATUS = 12'h00C;
  localparam logic [APB_ADDR_W-1:0] APB_RDATA  = 12'h010;

  // Controller register fields
  localparam int HC_LEG_HARD = 0;
  localparam int HC_LEG_SOFT = 1;
  localparam int HC_AUX_HARD = 2;
  localparam int HC_AUX_SOFT = 3;
  localparam int HC_GPIO_LSB = 4;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_CS_LSB   = 16;
  localparam int CMD_WRITE    = 19;
  localparam int STAT_BUSY    = 0;

  // Controller sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ADDR   = 4'h2,
    ST_STROBE = 4'h4,
    ST_WAIT   = 4'h8
  } host_state_e;

endpackage

// *** verilog/lbus_if.sv ***
`timescale 1ns/1ps
interface lbus_if;
  import boot_router_pkg::*;

  logic [NUM_CS-1:0] cs_n;
  logic              ale;
  logic [BUS_W-1:0]  ad;
  logic              rd;
  logic              wr;
  logic [BUS_W-1:0]  wdata;
  logic [BUS_W-1:0]  rdata;
  logic              ack;
  logic [GPIO_W-1:0] gpio_sel;
  logic              dbg_hard_reset_req;
  logic              dbg_soft_reset_req;
  logic              dbg2_hard_reset_req;
  logic              dbg2_soft_reset_req;

  // Router end
  modport dev (
    input  cs_n, ale, ad, rd, wr, wdata, gpio_sel,
    input  dbg_hard_reset_req, dbg_soft_reset_req, dbg2_hard_reset_req, dbg2_soft_reset_req,
    output rdata, ack
  );

  // Processor and debug end
  modport ctl (
    output cs_n, ale, ad, rd, wr, wdata, gpio_sel,
    output dbg_hard_reset_req, dbg_soft_reset_req, dbg2_hard_reset_req, dbg2_soft_reset_req,
    input  rdata, ack
  );
endinterface

// *** verilog/pin_sync2.sv ***
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_s;

  sync_s s;
  sync_s next_s;

  // Two-stage shift; only the second stage is read
  always_comb begin
    next_s      = s;
    next_s.meta = d;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.sync;

endmodule

// *** verilog/boot_bus_controller.sv ***
`timescale 1ns/1ps
module boot_bus_controller (
  // Clock and reset
  input  wire logic                                     REF_CLK,
  input  wire logic                                     ARST_N,
  // APB slave
  input  wire logic                                     PSEL,
  input  wire logic                                     PENABLE,
  input  wire logic                                     PWRITE,
  input  wire logic [boot_router_pkg::APB_ADDR_W-1:0]   PADDR,
  input  wire logic [boot_router_pkg::APB_DATA_W-1:0]   PWDATA,
  output logic      [boot_router_pkg::APB_DATA_W-1:0]   PRDATA,
  output logic                                          PREADY,
  output logic                                          PSLVERR,
  // Local bus and debug requests
  lbus_if.ctl                                           BUS
);
  import boot_router_pkg::*;

  typedef struct packed {
    host_state_e       state;
    logic [2:0]        cs_num;
    logic              write;
    logic [BUS_W-1:0]  addr;
    logic [BUS_W-1:0]  wdata;
    logic [BUS_W-1:0]  rdata;
    logic [3:0]        dbg;
    logic [GPIO_W-1:0] gpio;
    logic [NUM_CS-1:0] cs_n;
    logic              ale;
    logic              rd;
    logic              wr;
    logic              pready;
    logic              pslverr;
    logic [APB_DATA_W-1:0] prdata;
  } host_state_s;

  localparam host_state_s HOST_RESET = '{
    state:   ST_IDLE,
    cs_num:  CS_BOOT_NUM,
    cs_n:    7'h7F,
    default: '0
  };

  host_state_s s;
  host_state_s next_s;

  // Next-state logic
  always_comb begin
    logic                  setup;
    logic                  access;
    logic                  busy;
    logic                  unmapped;
    logic [APB_DATA_W-1:0] rd_val;
    setup    = 1'b0;
    access   = 1'b0;
    busy     = 1'b0;
    unmapped = 1'b0;
    rd_val   = '0;
    next_s   = s;

    busy     = (s.state != ST_IDLE);
    setup    = PSEL && !PENABLE && !s.pready;
    access   = PSEL && PENABLE && s.pready;
    unmapped = !(PADDR == APB_CTRL || PADDR == APB_CMD || PADDR == APB_WDATA ||
                 PADDR == APB_STATUS || PADDR == APB_RDATA);

    // Read value of the addressed register
    case (PADDR)
      APB_CTRL: begin
        rd_val[HC_LEG_HARD +: 4]      = s.dbg;
        rd_val[HC_GPIO_LSB +: GPIO_W] = s.gpio;
      end
      APB_CMD: begin
        rd_val[CMD_ADDR_LSB +: BUS_W] = s.addr;
        rd_val[CMD_CS_LSB +: 3]       = s.cs_num;
        rd_val[CMD_WRITE]             = s.write;
      end
      APB_WDATA:  rd_val[BUS_W-1:0] = s.wdata;
      APB_STATUS: rd_val[STAT_BUSY] = busy;
      APB_RDATA:  rd_val[BUS_W-1:0] = s.rdata;
      default:    rd_val = '0;
    endcase

    // Setup captures the answer; access releases it
    if (setup) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = unmapped;
      next_s.prdata  = rd_val;
    end
    if (access) begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
    end

    // Local bus sequencer
    case (s.state)
      ST_IDLE: begin
        next_s.state = ST_IDLE;
      end
      ST_ADDR: begin
        next_s.ale = 1'b0;
        if (s.cs_num <= CS_LAST_NUM) begin
          next_s.cs_n[s.cs_num] = 1'b0;
        end
        next_s.rd    = !s.write;
        next_s.wr    = s.write;
        next_s.state = ST_STROBE;
      end
      ST_STROBE: begin
        next_s.cs_n  = '1;
        next_s.rd    = 1'b0;
        next_s.wr    = 1'b0;
        next_s.state = (s.cs_num == CS_REGS_NUM) ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        if (BUS.ack) begin
          next_s.rdata = BUS.rdata;
          next_s.state = ST_IDLE;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
        next_s.cs_n  = '1;
        next_s.ale   = 1'b0;
        next_s.rd    = 1'b0;
        next_s.wr    = 1'b0;
      end
    endcase

    // Register writes at the access edge
    if (access && PWRITE && !unmapped) begin
      case (PADDR)
        APB_CTRL: begin
          next_s.dbg  = PWDATA[HC_LEG_HARD +: 4];
          next_s.gpio = PWDATA[HC_GPIO_LSB +: GPIO_W];
        end
        APB_WDATA: begin
          next_s.wdata = PWDATA[BUS_W-1:0];
        end
        APB_CMD: begin
          // launch a 16-bit transfer, ignored while busy
          if (!busy) begin
            next_s.addr   = PWDATA[CMD_ADDR_LSB +: BUS_W];
            next_s.cs_num = PWDATA[CMD_CS_LSB +: 3];
            next_s.write  = PWDATA[CMD_WRITE];
            next_s.ale    = 1'b1;
            next_s.state  = ST_ADDR;
          end
        end
        default: begin
          next_s.wdata = s.wdata;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= HOST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign PRDATA                  = s.prdata;
  assign PREADY                  = s.pready;
  assign PSLVERR                 = s.pslverr;
  assign BUS.cs_n                = s.cs_n;
  assign BUS.ale                 = s.ale;
  assign BUS.ad                  = s.addr;
  assign BUS.rd                  = s.rd;
  assign BUS.wr                  = s.wr;
  assign BUS.wdata               = s.wdata;
  assign BUS.gpio_sel            = s.gpio;
  assign BUS.dbg_hard_reset_req  = s.dbg[HC_LEG_HARD];
  assign BUS.dbg_soft_reset_req  = s.dbg[HC_LEG_SOFT];
  assign BUS.dbg2_hard_reset_req = s.dbg[HC_AUX_HARD];
  assign BUS.dbg2_soft_reset_req = s.dbg[HC_AUX_SOFT];

endmodule

// *** verification/boot_router_checker.sv ***
`timescale 1ns/1ps
module boot_router_checker
  import boot_router_pkg::*;
(
  // Clock and reset
  input wire logic               REF_CLK,
  input wire logic               ARST_N,
  // Local bus side
  input wire logic [NUM_CS-1:0]  cs_n,
  input wire logic               rd,
  input wire logic               wr,
  input wire logic               ack,
  input wire logic [GPIO_W-1:0]  gpio_sel,
  input wire logic               dbg_hard_reset_req,
  input wire logic               dbg_soft_reset_req,
  // Router outputs
  input wire logic               NOR_CS_N,
  input wire logic               EMU_CS_N,
  input wire logic [NAND_W-1:0]  NAND_CS_N,
  input wire logic               POWER_ON_RESET_IN_N,
  input wire logic               HARD_RESET_LINE_O,
  input wire logic               HARD_RESET_LINE_OE,
  input wire logic [MGMT1_W-1:0] MGMT1_EN,
  input wire logic [MGMT2_W-1:0] MGMT2_EN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  // Register space answers exactly one cycle later, once
  chk_regs_ack: assert property (!cs_n[CS_REGS] && (rd || wr) |=> ack)
    else $error("no ack after register access");
  chk_ack_cause: assert property (ack |-> $past(!cs_n[CS_REGS] && (rd || wr)))
    else $error("ack without register access");
  chk_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  // Register accesses never reach a flash device
  chk_regs_quiet: assert property (!cs_n[CS_REGS] |=> NOR_CS_N && EMU_CS_N && &NAND_CS_N)
    else $error("flash selected on register access");
  chk_flash_cause: assert property (!(NOR_CS_N && EMU_CS_N && &NAND_CS_N) |-> !(&$past(cs_n)))
    else $error("flash select without bus select");
  // Open-drain line is only ever pulled low
  chk_line_low: assert property (HARD_RESET_LINE_OE |-> HARD_RESET_LINE_O == 1'b0)
    else $error("hard reset line driven high");
  // Legacy connector requests reach the processor resets
  chk_soft_line: assert property ($rose(dbg_soft_reset_req) |=> HARD_RESET_LINE_OE)
    else $error("soft request not on hard reset line");
  chk_hard_por: assert property (dbg_hard_reset_req |=> !POWER_ON_RESET_IN_N)
    else $error("hard request not on power-on reset");
  // Management muxes follow a settled select
  chk_mgmt1_map: assert property ($stable(gpio_sel) [*3] |-> MGMT1_EN == (4'h1 << {gpio_sel[0], gpio_sel[1]}))
    else $error("first mux enable wrong");
  chk_mgmt2_map: assert property ($stable(gpio_sel) [*3] |-> MGMT2_EN == {&gpio_sel[3:2], !gpio_sel[2] & gpio_sel[3]})
    else $error("second mux enable wrong");
endmodule

// *** verification/test_boot_chip_select_router.sv ***
`timescale 1ns/1ps
module test_boot_chip_select_router;
  import boot_router_pkg::*;

  // Stimulus and observed signals
  logic        REF_CLK = 1'b0;
  logic        ARST_N  = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'h49;
  logic        pready, pslverr, cold = 1'b0, warm = 1'b0;
  logic [3:0]  boot_map = 4'h0, nand_cs_n, mgmt1_en;
  logic [2:0]  clk_sw = 3'h0, flash_hi, seen_hi;
  logic        nor_cs_n, emu_cs_n, por_n, hrl_o, hrl_oe, usb_id;
  logic [1:0]  mgmt2_en;
  logic [5:0]  seen;
  logic [3:0]  maps [7] = '{4'h0, 4'h3, 4'h7, 4'h8, 4'h9, 4'hA, 4'hF};
  int          n_fail = 0, num_checks = 0;

  lbus_if bus ();
  boot_chip_select_router boot_chip_select_router_inst (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .BUS(bus), .BOOT_MAP(boot_map), .CLK_SPEED_SW(clk_sw),
    .COLD_RST_REQ(cold), .WARM_RST_REQ(warm), .NOR_CS_N(nor_cs_n), .EMU_CS_N(emu_cs_n),
    .NAND_CS_N(nand_cs_n), .FLASH_ADDR_HI(flash_hi), .POWER_ON_RESET_IN_N(por_n),
    .HARD_RESET_LINE_O(hrl_o), .HARD_RESET_LINE_OE(hrl_oe), .USB_ID(usb_id),
    .MGMT1_EN(mgmt1_en), .MGMT2_EN(mgmt2_en));
  boot_bus_controller boot_bus_controller_inst (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS(bus));
  boot_router_checker boot_router_checker_inst (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .cs_n(bus.cs_n), .rd(bus.rd), .wr(bus.wr), .ack(bus.ack),
    .gpio_sel(bus.gpio_sel), .dbg_hard_reset_req(bus.dbg_hard_reset_req),
    .dbg_soft_reset_req(bus.dbg_soft_reset_req), .NOR_CS_N(nor_cs_n), .EMU_CS_N(emu_cs_n),
    .NAND_CS_N(nand_cs_n), .POWER_ON_RESET_IN_N(por_n), .HARD_RESET_LINE_O(hrl_o),
    .HARD_RESET_LINE_OE(hrl_oe), .MGMT1_EN(mgmt1_en), .MGMT2_EN(mgmt2_en));

  // Clock at 40 MHz
  always #12.5 REF_CLK = ~REF_CLK;

  // Remember the last flash select pattern and bank bits seen
  always @(posedge REF_CLK) begin
    if ({nor_cs_n, emu_cs_n, nand_cs_n} != 6'h3F) begin
      seen    <= {nor_cs_n, emu_cs_n, nand_cs_n};
      seen_hi <= flash_hi;
    end
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // Expected selects {nor, emu, nand[3:0]}, active low
  function automatic logic [5:0] exp_sel(input logic [3:0] m, input int c);
    logic [5:0] s;
    s = 6'h3F;
    if (m == 4'h9) begin
      if (c == 1) s[4] = 1'b0;
      else if (c == 2) s[0] = 1'b0;
      else if (c != 3 && c < 7) s[5] = 1'b0;
    end else begin
      if (c == 0) s[(m == 4'h8) ? 4 : 5] = 1'b0;
      else if (c == 1) s[(m == 4'h8) ? 5 : 4] = 1'b0;
      else if (c == 2) s[0] = 1'b0;
      else if (c > 3 && c < 7) s[c-3] = 1'b0;
    end
    return s;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge REF_CLK);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge REF_CLK);
    penable <= 1'b1;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Local bus transfer through the controller, waits until idle
  task automatic lb(input logic [2:0] c, input logic [15:0] a, input logic w, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    int          n = 0;
    apb(1'b1, APB_WDATA, {16'h0, d}, r, e);
    apb(1'b1, APB_CMD, {12'h0, w, c, a}, r, e);
    do begin
      apb(1'b0, APB_STATUS, 32'h0, r, e);
      n++;
    end while (r[STAT_BUSY] !== 1'b0 && n < 40);
    if (r[STAT_BUSY] !== 1'b0) n_fail++;
  endtask

  task automatic rr(input logic [1:0] idx, output logic [31:0] r);
    logic e;
    lb(3'(CS_REGS), {14'(xs()), idx}, 1'b0, 16'h0);
    apb(1'b0, APB_RDATA, 32'h0, r, e);
  endtask

  task automatic rst(input logic [3:0] m);
    boot_map <= m;
    ARST_N <= 1'b0;
    cyc(6);
    ARST_N <= 1'b1;
    cyc(8);
  endtask

  // Watchdog
  initial begin
    cyc(40000);
    n_fail++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] a;
    foreach (maps[i]) begin
      rst(maps[i]);
      boot_map <= ~maps[i];
      for (int c = 0; c < 8; c++) begin
        a = 16'(xs());
        seen = 6'h3F;
        lb(3'(c), a, 1'b0, 16'h0);
        chk("route", 32'(exp_sel(maps[i], c)), 32'(seen));
        if (c == 0) chk("bank", 32'(maps[i][3] ? a[15:13] : a[15:13] ^ maps[i][2:0]), 32'(seen_hi));
      end
      rr(REG_STATUS, r);
      chk("status", {27'h0, 1'b1, maps[i]}, r);
    end
    $display("test routing done");
    clk_sw <= 3'(xs());
    a = 16'(xs());
    lb(3'(CS_REGS), {14'h0, REG_AUX}, 1'b1, a);
    rr(REG_AUX, r);
    chk("aux", 32'(a), r);
    lb(3'(CS_REGS), {14'h0, REG_CLK}, 1'b1, 16'h0008);
    rr(REG_CLK, r);
    chk("clk_arb", {27'h0, 2'b01, clk_sw}, r);
    lb(3'(CS_REGS), {14'h0, REG_CLK}, 1'b1, 16'h0000);
    rr(REG_CLK, r);
    chk("clk_fixed", {27'h0, 2'b10, clk_sw}, r);
    lb(3'(CS_REGS), {14'h0, REG_CTRL}, 1'b1, 16'h0001);
    cyc(2);
    chk("usb_id", 32'h1, 32'(usb_id));
    lb(3'(CS_REGS), {14'h0, REG_CTRL}, 1'b1, 16'h0002);
    cyc(2);
    chk("pulse_on", 32'h0, 32'(por_n));
    cyc(45);
    chk("pulse_off", 32'h1, 32'(por_n));
    $display("test registers done");
    apb(1'b1, APB_CTRL, 32'h1, r, e);
    cyc(2);
    chk("hard_req", 32'h0, 32'(por_n));
    apb(1'b1, APB_CTRL, 32'h2, r, e);
    cyc(2);
    chk("soft_req", 32'h1, 32'(hrl_oe));
    lb(3'(CS_REGS), {14'h0, REG_CTRL}, 1'b1, 16'h0004);
    chk("dbg_mux", 32'h0, 32'(hrl_oe));
    apb(1'b1, APB_CTRL, 32'h4, r, e);
    cyc(2);
    chk("dbg2_hard", 32'h0, 32'(por_n));
    apb(1'b1, APB_CTRL, 32'h0, r, e);
    cold <= 1'b1;
    cyc(5);
    chk("cold", 32'h0, 32'(por_n));
    cold <= 1'b0;
    warm <= 1'b1;
    cyc(5);
    chk("warm", 32'h0, 32'(por_n));
    warm <= 1'b0;
    $display("test resets done");
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, APB_CTRL, {24'h0, 4'(k), 4'h0}, r, e);
      cyc(4);
      chk("mgmt1", 32'(4'h1 << {k[0], k[1]}), 32'(mgmt1_en));
      chk("mgmt2", {30'h0, k[2] & k[3], !k[2] & k[3]}, 32'(mgmt2_en));
    end
    apb(1'b0, 12'hFFC, 32'h0, r, e);
    chk("slverr", 32'h1, 32'(e));
    chk("prdata", 32'h0, r);
    $display("test muxes done");
    report_and_stop;
  end
endmodule
